// [src/clk_sync_pkg.sv]
// Constants and types for the converter clock synchronisation block
package clk_sync_pkg;
  localparam int unsigned CLK_HZ         = 125_000_000;
  localparam int unsigned NOM_HZ         = 280_000;
  localparam int unsigned TOL_PCT        = 5;
  // Nominal period and the accepted window, in system cycles
  localparam int unsigned NOM_CYC        = CLK_HZ / NOM_HZ;
  localparam int unsigned MIN_CYC        = (CLK_HZ + NOM_HZ * (100 + TOL_PCT) / 100 - 1)
                                           / (NOM_HZ * (100 + TOL_PCT) / 100);
  localparam int unsigned MAX_CYC        = CLK_HZ / (NOM_HZ * (100 - TOL_PCT) / 100);
  // Loss declared after this many nominal periods without an edge
  localparam int unsigned LOSS_PERIODS   = 4;
  localparam int unsigned LOSS_CYC       = NOM_CYC * LOSS_PERIODS;
  localparam int unsigned DELAY_STEP_MS  = 100;
  localparam int unsigned DELAY_STEP_CYC = CLK_HZ / 1000 * DELAY_STEP_MS;
  localparam int unsigned LOCK_PERIODS   = 4;
  localparam int unsigned CNT_W          = 12;
  localparam int unsigned STRAP_W        = 5;
  localparam logic [7:0]  ADDR_BASE      = 8'h_00B0;

  typedef logic [CNT_W-1:0] cnt_t;

  typedef enum logic [1:0] {
    VARIANT_SINGLE,
    VARIANT_MULTI
  } variant_e;

  typedef struct packed {
    logic       controller_ready;
    logic       brown_in_ok;
    logic       bulk_low;
    logic       correction_enable;
  } power_state_s;

  typedef struct packed {
    logic [7:0] bus_addr;
    logic [3:0] delay_steps;
    logic [3:0] lag_num;
    logic [3:0] lag_den;
  } strap_cfg_s;

  // Strap index to address, read delay and lag fraction
  function automatic strap_cfg_s decode_strap(input logic [STRAP_W-1:0] idx);
    strap_cfg_s c;
    c.bus_addr = ADDR_BASE + {2'b00, idx, 1'b0};
    c.delay_steps = 4'h_0;
    c.lag_num = 4'h_1;
    c.lag_den = 4'h_2;
    if (idx < 5'd2)
    begin
      c.delay_steps = idx[3:0];
      c.lag_den = 4'h_2;
    end
    else if (idx < 5'd5)
    begin
      c.delay_steps = 4'(idx - 5'd2);
      c.lag_den = 4'h_3;
    end
    else if (idx < 5'd9)
    begin
      c.delay_steps = 4'(idx - 5'd5);
      c.lag_den = 4'h_4;
    end
    else if (idx < 5'd19)
    begin
      c.delay_steps = 4'(idx - 5'd9);
      c.lag_den = 4'h_5;
    end
    else if (idx < 5'd21)
    begin
      c.delay_steps = 4'(idx - 5'd19);
      c.lag_den = 4'h_2;
    end
    else if (idx < 5'd24)
    begin
      c.delay_steps = 4'(idx - 5'd21);
      c.lag_den = 4'h_3;
    end
    else if (idx < 5'd28)
    begin
      c.delay_steps = 4'(idx - 5'd24);
      c.lag_den = 4'h_4;
    end
    else if (idx < 5'd30)
    begin
      c.delay_steps = 4'(idx - 5'd28);
      c.lag_den = 4'h_2;
    end
    else
    begin
      c.delay_steps = 4'h_0;
      c.lag_den = 4'h_4;
    end
    return c;
  endfunction : decode_strap
endpackage : clk_sync_pkg

// [src/clk_period_meter.sv]
// Input clock period meter with loss detection
`timescale 1ns/1ps
`default_nettype none
module clk_period_meter
  import clk_sync_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              sync_in,
  output logic                   rise,
  output logic                   valid,
  output clk_sync_pkg::cnt_t     period
);
  logic [1:0] sync_q;
  logic [1:0] sync_d;
  logic       prev_q;
  logic       prev_d;
  cnt_t       cnt_q;
  cnt_t       cnt_d;
  cnt_t       per_q;
  cnt_t       per_d;
  logic [2:0] good_q;
  logic [2:0] good_d;
  logic       edge_w;
  logic       in_range;

  always_comb
  begin
    sync_d   = {sync_q[0], sync_in};
    prev_d   = sync_q[1];
    edge_w   = sync_q[1] & ~prev_q;
    in_range = (cnt_q >= cnt_t'(MIN_CYC)) && (cnt_q <= cnt_t'(MAX_CYC));
    per_d    = per_q;
    good_d   = good_q;
    cnt_d    = (cnt_q == cnt_t'(LOSS_CYC)) ? cnt_q : cnt_q + cnt_t'(1);
    if (edge_w)
    begin
      cnt_d = cnt_t'(1);
      per_d = cnt_q;
      // Out of range periods count as no clock
      if (!in_range)
        good_d = 3'h_0;
      else if (good_q != 3'(LOCK_PERIODS))
        good_d = good_q + 3'h_1;
    end
    else if (cnt_q == cnt_t'(LOSS_CYC))
      good_d = 3'h_0;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      sync_q <= 2'h_0;
      prev_q <= 1'b0;
      cnt_q  <= '0;
      per_q  <= '0;
      good_q <= 3'h_0;
    end
    else
    begin
      sync_q <= sync_d;
      prev_q <= prev_d;
      cnt_q  <= cnt_d;
      per_q  <= per_d;
      good_q <= good_d;
    end
  end

  assign rise   = edge_w;
  assign valid  = (good_q == 3'(LOCK_PERIODS));
  assign period = per_q;
endmodule : clk_period_meter
`default_nettype wire

// [src/clk_sync_phase_shift.sv]
// Clock synchronisation, fallback and phase-shifted chain output
`timescale 1ns/1ps
`default_nettype none
module clk_sync_phase_shift
  import clk_sync_pkg::*;
#(
  parameter int unsigned DELAY_STEP = DELAY_STEP_CYC
)
(
  input  wire logic                      clk,
  input  wire logic                      rst_b,
  input  wire logic                      sync_in,
  input  wire logic [STRAP_W-1:0]        addr_strap,
  input  wire clk_sync_pkg::variant_e    variant,
  input  wire clk_sync_pkg::power_state_s pwr,
  output logic                           sync_out,
  output logic                           phase_a,
  output logic                           phase_b,
  output logic                           locked,
  output logic [7:0]                     bus_addr
);
  import clk_sync_pkg::*;

  typedef enum logic [1:0] {
    ST_WAIT,
    ST_DELAY,
    ST_RUN
  } start_e;

  logic       rise;
  logic       in_valid;
  cnt_t       in_period;
  start_e     st_q;
  start_e     st_d;
  strap_cfg_s cfg_q;
  strap_cfg_s cfg_d;
  logic [31:0] dly_q;
  logic [31:0] dly_d;
  logic [3:0] step_q;
  logic [3:0] step_d;
  logic       phase_ok_q;
  logic       phase_ok_d;
  cnt_t       per_q;
  cnt_t       per_d;
  cnt_t       ph_q;
  cnt_t       ph_d;
  cnt_t       lag_q;
  cnt_t       lag_d;
  logic       out_q;
  logic       out_d;
  logic       pa_q;
  logic       pa_d;
  logic       pb_q;
  logic       pb_d;
  logic       lock_q;
  logic       lock_d;
  cnt_t       hi_q;
  cnt_t       hi_d;
  logic       allow;
  logic       ext_ok;
  logic       wrap;

  clk_period_meter clk_period_meter_i
  (
    .clk    (clk),
    .rst_b  (rst_b),
    .sync_in(sync_in),
    .rise   (rise),
    .valid  (in_valid),
    .period (in_period)
  );

  always_comb
  begin
    allow = pwr.controller_ready;
    if (variant == VARIANT_MULTI)
      allow = pwr.brown_in_ok & pwr.correction_enable & ~pwr.bulk_low;
    // Phase locking only if set up at start-up
    ext_ok = in_valid & phase_ok_q;
    st_d       = st_q;
    cfg_d      = cfg_q;
    dly_d      = dly_q;
    step_d     = step_q;
    phase_ok_d = phase_ok_q;
    case (st_q)
      ST_WAIT:
      begin
        cfg_d  = decode_strap(addr_strap);
        dly_d  = 32'h_0000_0000;
        step_d = 4'h_0;
        phase_ok_d = 1'b0;
        if (allow)
          st_d = ST_DELAY;
      end
      ST_DELAY:
      begin
        if (step_q == cfg_q.delay_steps)
        begin
          phase_ok_d = in_valid | (cfg_q.delay_steps == 4'h_0);
          st_d = ST_RUN;
        end
        else if (dly_q == DELAY_STEP - 1)
        begin
          dly_d  = 32'h_0000_0000;
          step_d = step_q + 4'h_1;
        end
        else
          dly_d = dly_q + 32'h_0000_0001;
      end
      default:
      begin
        if (!allow)
          st_d = ST_WAIT;
      end
    endcase
  end

  always_comb
  begin
    per_d  = per_q;
    lag_d  = lag_q;
    lock_d = ext_ok & allow;
    ph_d   = ph_q + cnt_t'(1);
    // Realign to the chain's input edge
    // Input edge also closes the period, so a faster chain restarts it before the count runs out
    wrap   = (ph_q >= per_q - cnt_t'(1)) || (ext_ok && rise);
    if (wrap)
    begin
      ph_d  = '0;
      per_d = ext_ok ? in_period : cnt_t'(NOM_CYC);
      // Lag of one period over module count
      lag_d = cnt_t'((32'(per_d) * 32'(cfg_q.lag_num)) / 32'(cfg_q.lag_den));
    end
    hi_d  = (hi_q != '0) ? hi_q - cnt_t'(1) : '0;
    pa_d  = pa_q;
    pb_d  = pb_q;
    // Output cut on the same edge
    if (st_q == ST_RUN && allow)
    begin
      // Fixed 30 percent duty to sit inside the accepted band
      // Pulse only starts at the lag point, so a realign never leaves a runt
      if (ph_q == lag_q)
        hi_d = (per_q * cnt_t'(3)) / cnt_t'(10);
      // Each phase toggles once every period, phase_b opposite to phase_a
      if (ph_q == '0)
      begin
        pa_d = ~pa_q;
        pb_d = pa_q;
      end
    end
    else
    begin
      hi_d = '0;
      pa_d = 1'b0;
      pb_d = 1'b0;
    end
    out_d = (hi_d != '0);
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      st_q       <= ST_WAIT;
      cfg_q      <= '0;
      dly_q      <= 32'h_0000_0000;
      step_q     <= 4'h_0;
      phase_ok_q <= 1'b0;
      per_q      <= cnt_t'(NOM_CYC);
      ph_q       <= '0;
      lag_q      <= '0;
      out_q      <= 1'b0;
      pa_q       <= 1'b0;
      pb_q       <= 1'b0;
      lock_q     <= 1'b0;
      hi_q       <= '0;
    end
    else
    begin
      st_q       <= st_d;
      cfg_q      <= cfg_d;
      dly_q      <= dly_d;
      step_q     <= step_d;
      phase_ok_q <= phase_ok_d;
      per_q      <= per_d;
      ph_q       <= ph_d;
      lag_q      <= lag_d;
      out_q      <= out_d;
      pa_q       <= pa_d;
      pb_q       <= pb_d;
      lock_q     <= lock_d;
      hi_q       <= hi_d;
    end
  end

  assign sync_out = out_q;
  assign phase_a  = pa_q;
  assign phase_b  = pb_q;
  assign locked   = lock_q;
  assign bus_addr = cfg_q.bus_addr;
endmodule : clk_sync_phase_shift
`default_nettype wire

// [verif/clk_sync_phase_shift_properties.sv]
// Port checker for the clock synchronisation block
`timescale 1ns/1ps
`default_nettype none
module clk_sync_phase_shift_properties
  import clk_sync_pkg::*;
#(
  parameter int unsigned DELAY_STEP = DELAY_STEP_CYC
)
(
  input wire logic                       clk,
  input wire logic                       rst_b,
  input wire logic                       sync_in,
  input wire logic [STRAP_W-1:0]         addr_strap,
  input wire clk_sync_pkg::variant_e     variant,
  input wire clk_sync_pkg::power_state_s pwr,
  input wire logic                       sync_out,
  input wire logic                       phase_a,
  input wire logic                       phase_b,
  input wire logic                       locked,
  input wire logic [7:0]                 bus_addr
);
  localparam int LIM = LOSS_CYC + 8;
  logic        allow, in_q;
  logic [15:0] quiet_q, quiet_d;
  assign allow = (variant == VARIANT_SINGLE) ? pwr.controller_ready
                 : (pwr.brown_in_ok && pwr.correction_enable && !pwr.bulk_low);
  // Saturates so a long silence never wraps back
  always_comb
  begin
    quiet_d = (sync_in != in_q) ? 16'h_0000 : quiet_q + 16'(quiet_q < 16'(LIM));
  end
  always_ff @(posedge clk)
  begin
    in_q    <= sync_in;
    quiet_q <= rst_b ? quiet_d : 16'h_0000;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_reset_quiet: assert property (
    $rose(rst_b) |-> !sync_out && !locked && bus_addr == 8'h_00)
    else $error("outputs not clear after reset");
  a_single_gate: assert property (
    variant == VARIANT_SINGLE && !pwr.controller_ready |=> !sync_out && !locked)
    else $error("output before controller ready");
  a_multi_start: assert property (
    variant == VARIANT_MULTI && !(pwr.brown_in_ok && pwr.correction_enable) |=> !sync_out)
    else $error("output without brown-in and enable");
  a_bulk_stop: assert property (
    variant == VARIANT_MULTI && pwr.bulk_low |=> !sync_out && !phase_a && !phase_b)
    else $error("output kept on low bulk");
  a_loss_unlock: assert property (
    quiet_q == 16'(LIM) |-> !locked)
    else $error("lock held on silent input");
  a_high_hold: assert property (
    $rose(sync_out) ##0 allow[*8] |=> sync_out)
    else $error("output high pulse cut short");
  a_addr_map: assert property (
    sync_out |-> bus_addr == ADDR_BASE + {2'b00, addr_strap, 1'b0})
    else $error("bus address does not follow strap");
  a_phase_split: assert property (
    !($rose(phase_a) && $rose(phase_b)))
    else $error("phases switch together");
endmodule : clk_sync_phase_shift_properties
bind clk_sync_phase_shift clk_sync_phase_shift_properties #(.DELAY_STEP(DELAY_STEP))
  clk_sync_phase_shift_properties_i (.clk(clk), .rst_b(rst_b), .sync_in(sync_in),
  .addr_strap(addr_strap), .variant(variant), .pwr(pwr), .sync_out(sync_out),
  .phase_a(phase_a), .phase_b(phase_b), .locked(locked), .bus_addr(bus_addr));
`default_nettype wire

// [verif/chain_clk_src.sv]
// Far-side chain clock source for the sync input
`timescale 1ns/1ps
`default_nettype none
module chain_clk_src
  import clk_sync_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               run,
  input  wire clk_sync_pkg::cnt_t per,
  output logic                    line
);
  cnt_t cnt_q, cnt_d;
  logic line_d;
  // 30 percent high; a stopped source holds low
  always_comb
  begin
    cnt_d  = (!run || cnt_q >= per - 12'h_001) ? 12'h_000 : cnt_q + 12'h_001;
    line_d = run && (cnt_q < per * 12'h_003 / 12'h_00A);
  end
  always_ff @(posedge clk)
  begin
    cnt_q <= cnt_d;
    line  <= line_d;
  end
endmodule : chain_clk_src
`default_nettype wire

// [verif/clk_sync_phase_shift_test.sv]
// Self-checking bench for the clock synchronisation block
`timescale 1ns/1ps
`default_nettype none
module clk_sync_phase_shift_test;
  import clk_sync_pkg::*;
  // Read delay step long enough for the input to be measured first
  localparam int DS = 2000;
  typedef struct {int lo; int hi; logic [7:0] addr; bit ck; logic lk; int lag;} note_s;
  logic         clk = 1'b0;
  logic         rst_b = 1'b0;
  logic         src_run = 1'b0;
  logic         sync_in, sync_out, phase_a, phase_b, locked, so_p, si_p, pa_p;
  logic [7:0]   bus_addr;
  logic [4:0]   strap = 5'h_00;
  logic [15:0]  seed = 16'h_0056;
  cnt_t         per = 12'h_1BE;
  variant_e     variant = VARIANT_SINGLE;
  power_state_s pwr = 4'h_0;
  note_s        q[$];
  int           cyc, ref_c, in_c, bad_count, num_checks;
  bit           quiet;
  always #4 clk = ~clk;
  chain_clk_src chain_clk_src_i (.clk(clk), .run(src_run), .per(per), .line(sync_in));
  clk_sync_phase_shift #(.DELAY_STEP(DS)) clk_sync_phase_shift_i (.clk(clk), .rst_b(rst_b),
    .sync_in(sync_in), .addr_strap(strap), .variant(variant), .pwr(pwr),
    .sync_out(sync_out), .phase_a(phase_a), .phase_b(phase_b), .locked(locked),
    .bus_addr(bus_addr));
  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up
  task automatic chk(input string what, input logic ok, input logic [15:0] exp,
                     input logic [15:0] got);
    num_checks++;
    if (ok !== 1'b1)
    begin
      bad_count++;
      $display("Error %s expected %0d seen %0d", what, exp, got);
    end
  endtask : chk
  function automatic int rnd_per();
    seed = seed ^ (seed << 7);
    seed = seed ^ (seed >> 9);
    seed = seed ^ (seed << 8);
    return 430 + int'(seed % 16'h_0024);
  endfunction : rnd_per
  task automatic push(input int lo, input int hi, input bit ck, input logic lk, input int lag);
    q.push_back('{lo, hi, ADDR_BASE + {2'b00, strap, 1'b0}, ck, lk, lag});
  endtask : push
  task automatic wait_q();
    int i;
    for (i = 0; i < 30000 && q.size() > 0; i++)
      @(negedge clk);
    if (q.size() > 0)
    begin
      chk("pending", 1'b0, 16'h_0000, 16'(q.size()));
      wrap_up();
    end
  endtask : wait_q
  task automatic run_case(input variant_e v, input logic [4:0] s, input int p, input int nm,
                          input int st, input int drop, input bit cut);
    int i;
    @(negedge clk);
    quiet = 1'b0;
    variant = v;
    strap = s;
    src_run = p > 0;
    per = cnt_t'(p > 0 ? p : NOM_CYC);
    repeat (4) @(negedge clk);
    push(st * DS, st * DS + 2 * MAX_CYC + 20, 1'b0, 1'b0, 0);
    for (i = 0; i < 6; i++)
      push(1, 2 * MAX_CYC, 1'b0, 1'b0, 0);
    for (i = 0; i < 2; i++)
      if (p >= MIN_CYC && p <= MAX_CYC)
        push(p - 2, p + 2, 1'b1, 1'b1, p / nm);
      else
        push(NOM_CYC - 1, NOM_CYC + 1, 1'b1, 1'b0, 0);
    ref_c = cyc;
    pwr = power_state_s'(v == VARIANT_SINGLE ? 4'h_8 : 4'h_5);
    if (cut)
    begin
      wait_q();
      src_run = 1'b0;
      for (i = 0; i < 6; i++)
        push(MIN_CYC - 4, 2 * MAX_CYC, 1'b0, 1'b0, 0);
      push(NOM_CYC - 1, NOM_CYC + 1, 1'b1, 1'b0, 0);
    end
    wait_q();
    @(negedge clk);
    case (drop)
      0: pwr.controller_ready = 1'b0;
      1: pwr.bulk_low = 1'b1;
      2: pwr.correction_enable = 1'b0;
      default: pwr.brown_in_ok = 1'b0;
    endcase
    quiet = 1'b1;
    repeat (2 * MAX_CYC) @(negedge clk);
  endtask : run_case
  always @(posedge clk)
  begin
    note_s n;
    int    d;
    cyc = cyc + 1;
    d = cyc - ref_c;
    if (sync_in && !si_p)
      in_c = cyc;
    if (sync_out && !so_p)
    begin
      if (q.size() > 0)
      begin
        n = q.pop_front();
        chk("gap", d >= n.lo && d <= n.hi, 16'(n.lo), 16'(d));
        chk("bus_addr", bus_addr === n.addr, {8'h_00, n.addr}, {8'h_00, bus_addr});
        if (n.ck)
          chk("locked", locked === n.lk, 16'(n.lk), {15'h_0000, locked});
        d = cyc - in_c;
        if (n.lag > 0)
          chk("lag", d >= n.lag - 2 && d <= n.lag + 8, 16'(n.lag), 16'(d));
        if (n.ck)
          chk("phase_a", phase_a !== pa_p && phase_b === ~phase_a,
              16'(!pa_p), 16'(phase_a));
        pa_p = phase_a;
      end
      else if (quiet)
        chk("idle", 1'b0, 16'h_0000, 16'h_0001);
      ref_c = cyc;
    end
    so_p = sync_out;
    si_p = sync_in;
  end
  initial
  begin
    repeat (4) @(negedge clk);
    rst_b = 1'b1;
    run_case(VARIANT_SINGLE, 5'h_00, 0, 2, 0, 0, 1'b0);
    run_case(VARIANT_SINGLE, 5'h_01, rnd_per(), 2, 1, 0, 1'b1);
    run_case(VARIANT_MULTI, 5'h_04, rnd_per(), 3, 2, 1, 1'b0);
    rst_b = 1'b0;
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    run_case(VARIANT_MULTI, 5'h_06, 300, 4, 1, 2, 1'b0);
    run_case(VARIANT_MULTI, 5'h_00, rnd_per(), 2, 0, 3, 1'b0);
    wrap_up();
  end
endmodule : clk_sync_phase_shift_test
`default_nettype wire
